// ==== ee_regs.svh ====
// Purpose: constants of the serial nonvolatile memory command logic
// Assumes: included by bare name; definitions only
// Notes:   times kept in printed units, cycle counts derived from the clock rate
//
// Function
// - Idle status read returns lock bits; upper five bits read zero.
// - Status read shows all ones while a nonvolatile write runs.
// - Status bit pointer keeps advancing on clocks during a busy read.
// - Write bits following write-enable in the same selection are ignored.
// - Sixteen address bits follow; only the low ten are used.
// - Up to sixteen data bytes, all inside one page.
// - Page write address wraps to the start of the same page.
// - Write starts only if select rises right after a data byte's last bit.
// - Area-lock accepted only with the write latch set beforehand.
// - Area-lock opcode is followed by one byte; low three bits select area.
// - Select rising after area-lock stores the lock byte nonvolatilely.
// - Extra lock bytes replace earlier ones; the last one is stored.
// - After power-up: standby, output undriven, write latch cleared.
// - No instruction accepted before a select high-to-low after power-up.
// - Opcode 06h sets the write latch, 04h clears it.
// - Opcode 05h reads lock setting and busy state.
// - Opcode 02h writes the array, 03h reads it.
// - Opcodes, addresses and data travel most significant bit first.
// - Write latch clears when a write cycle completes.
// - Array read streams bytes, address wraps from 03FFh to 0000h.
// - Input sampled on clock rise, output changes after clock fall.
// - Write-protect low refuses writes but never stops a running one.
`ifndef EE_REGS_SVH
`define EE_REGS_SVH

// ****************************************
// Opcodes
// ****************************************
`define EE_OP_SET_WRITE_LATCH   8'h06
`define EE_OP_CLEAR_WRITE_LATCH 8'h04
`define EE_OP_AREA_LOCK         8'h01
`define EE_OP_READ_STATUS       8'h05
`define EE_OP_WRITE             8'h02
`define EE_OP_READ              8'h03

// ****************************************
// Status byte layout and reset
// ****************************************
`define EE_STAT_LOCK_MSB 2
`define EE_STAT_LOCK_LSB 0
`define EE_STAT_PAD_W    5
`define EE_LOCK_RESET    3'h0
`define EE_BUSY_STATUS   8'hFF

// ****************************************
// Frame bit positions and timing
// ****************************************
`define EE_LAST_ADDR_BIT 5'h17
`define EE_T_WC_MS       10
`define EE_CLK_KHZ       25000
`define EE_WC_CYCLES     (`EE_T_WC_MS * `EE_CLK_KHZ)

`endif

// ==== ee_pkg.sv ====
// Purpose: types shared by the serial nonvolatile memory command logic
// Assumes: nothing
// Notes:   link states Gray coded along opcode, address, read data
`default_nettype none
package ee_pkg;

   typedef enum logic [2:0] {
      EE_LK_OPC    = 3'h0,
      EE_LK_ADDR   = 3'h1,
      EE_LK_RDATA  = 3'h3,
      EE_LK_STAT   = 3'h2,
      EE_LK_DATA   = 3'h6,
      EE_LK_LOCK   = 3'h7,
      EE_LK_IGNORE = 3'h5
   } ee_link_state_t;

   typedef enum logic [2:0] {
      EE_CMD_NONE        = 3'h0,
      EE_CMD_SET_LATCH   = 3'h1,
      EE_CMD_CLEAR_LATCH = 3'h2,
      EE_CMD_WRITE       = 3'h3,
      EE_CMD_LOCK        = 3'h4,
      EE_CMD_READ        = 3'h5
   } ee_cmd_t;

endpackage
`default_nettype wire

// ==== ee_cmd.sv ====
// Purpose: instruction decoder and write control of a serial nonvolatile memory
// Assumes: serial clock is a clock port that runs only inside a selection
// Notes:   array and page buffer are quasi-static across the domain boundary
`timescale 1ns/1ps
`default_nettype none
`include "ee_regs.svh"
module ee_cmd #(
   parameter int DEPTH        = 1024,
   parameter int PAGE_BYTES   = 16,
   parameter int WRITE_CYCLES = `EE_WC_CYCLES
) (
   // Core clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       reset_in,
   // Serial port pins
   input  wire logic       sck_in,
   input  wire logic       cs_n_in,
   input  wire logic       si_in,
   input  wire logic       wp_n_in,
   output var  logic       so_out,
   output var  logic       so_oe_out,
   // Observed state
   output var  logic       busy_out,
   output var  logic       write_latch_out,
   output var  logic [2:0] lock_area_select_out
);
   import ee_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam int PW = $clog2(PAGE_BYTES);
   localparam int TW = $clog2(WRITE_CYCLES + 1);

   // ****************************************
   // Storage
   // ****************************************
   logic [7:0] mem [DEPTH];
   logic [7:0] l_buf [PAGE_BYTES];

   // ****************************************
   // Link domain signals
   // ****************************************
   logic           l_clr;
   ee_link_state_t l_state, next_l_state;
   logic [4:0]     l_cnt, next_l_cnt;
   logic [6:0]     l_sr, next_l_sr;
   logic [AW-1:0]  l_addr, next_l_addr;
   logic [7:0]     l_tx, next_l_tx;
   logic [AW-PW-1:0] l_page, next_l_page;
   logic [PW-1:0]  l_ptr, next_l_ptr;
   logic [PAGE_BYTES-1:0] l_mask, next_l_mask;
   logic [7:0]     l_lock, next_l_lock;
   ee_cmd_t        h_cmd, next_h_cmd;
   logic           h_ok, next_h_ok;
   logic           busy_l1, busy_l2, arm_l1, arm_l2;
   logic           next_so, next_so_oe;
   logic [7:0]     byte_in;
   logic           byte_end;
   logic [7:0]     lock_setting_status;

   // ****************************************
   // Core domain signals
   // ****************************************
   logic          cs_s1, cs_s2, cs_s3, wp_s1, wp_s2;
   logic          armed, next_armed;
   logic          wel, next_wel;
   logic          busy, next_busy;
   logic [TW-1:0] timer, next_timer;
   logic [2:0]    lock_area, next_lock_area;
   logic          wp_drop, next_wp_drop;
   logic          commit_wr;
   logic          cs_rise;

   // Deselect ends a frame; reset also clears it so output starts undriven
   assign l_clr       = cs_n_in | reset_in;
   assign byte_in     = {l_sr, si_in};
   assign byte_end    = (l_cnt[2:0] == 3'h7);
   assign lock_setting_status = {{`EE_STAT_PAD_W{1'b0}}, lock_area};

   // ****************************************
   // Link frame decoder
   // ****************************************
   always_comb begin
      next_l_state = l_state;
      next_l_cnt   = l_cnt + 5'h01;
      next_l_sr    = byte_in[6:0];
      next_l_addr  = l_addr;
      next_l_tx    = l_tx;
      next_l_page  = l_page;
      next_l_ptr   = l_ptr;
      next_l_mask  = l_mask;
      next_l_lock  = l_lock;
      next_h_cmd   = h_cmd;
      next_h_ok    = 1'b0;
      unique case (l_state)
         EE_LK_OPC: begin
            if (byte_end) begin
               next_l_state = EE_LK_IGNORE;
               if (arm_l2) begin
                  unique case (byte_in)
                     `EE_OP_SET_WRITE_LATCH: begin
                        next_h_cmd = EE_CMD_SET_LATCH;
                        next_h_ok  = 1'b1;
                     end
                     `EE_OP_CLEAR_WRITE_LATCH: begin
                        next_h_cmd = EE_CMD_CLEAR_LATCH;
                        next_h_ok  = 1'b1;
                     end
                     `EE_OP_READ_STATUS: begin
                        next_h_cmd   = EE_CMD_NONE;
                        next_l_state = EE_LK_STAT;
                        next_l_tx    = busy_l2 ? `EE_BUSY_STATUS : lock_setting_status;
                     end
                     `EE_OP_WRITE: begin
                        next_h_cmd   = EE_CMD_WRITE;
                        next_l_state = EE_LK_ADDR;
                     end
                     `EE_OP_READ: begin
                        next_h_cmd   = EE_CMD_READ;
                        next_l_state = EE_LK_ADDR;
                     end
                     `EE_OP_AREA_LOCK: begin
                        next_h_cmd   = EE_CMD_LOCK;
                        next_l_state = EE_LK_LOCK;
                     end
                     default: next_h_cmd = EE_CMD_NONE;
                  endcase
               end else begin
                  next_h_cmd = EE_CMD_NONE;
               end
            end
         end
         EE_LK_ADDR: begin
            next_l_addr = {l_addr[AW-2:0], si_in};
            if (l_cnt == `EE_LAST_ADDR_BIT) begin
               if (h_cmd == EE_CMD_READ) begin
                  next_l_state = EE_LK_RDATA;
                  next_l_tx    = mem[next_l_addr];
                  next_l_addr  = next_l_addr + 1'b1;
               end else begin
                  next_l_state = EE_LK_DATA;
                  next_l_page  = next_l_addr[AW-1:PW];
                  next_l_ptr   = next_l_addr[PW-1:0];
                  next_l_mask  = '0;
               end
            end
         end
         EE_LK_RDATA: begin
            if (byte_end) begin
               next_l_tx   = mem[l_addr];
               next_l_addr = l_addr + 1'b1;
            end
         end
         EE_LK_STAT: begin
            // Pointer runs on regardless, so busy only swaps the byte
            if (byte_end) begin
               next_l_tx = busy_l2 ? `EE_BUSY_STATUS : lock_setting_status;
            end
         end
         EE_LK_DATA: begin
            if (byte_end) begin
               next_l_mask[l_ptr] = 1'b1;
               next_l_ptr         = l_ptr + 1'b1;
               next_h_ok          = 1'b1;
            end
         end
         EE_LK_LOCK: begin
            if (byte_end) begin
               next_l_lock = byte_in;
               next_h_ok   = 1'b1;
            end
         end
         EE_LK_IGNORE: begin
            next_l_state = EE_LK_IGNORE;
         end
         default: next_l_state = EE_LK_IGNORE;
      endcase
   end

   // Frame state, cleared whenever the device is deselected
   always_ff @(posedge sck_in or posedge l_clr) begin
      if (l_clr) begin
         l_state <= EE_LK_OPC;
         l_cnt   <= 5'h00;
         l_sr    <= 7'h00;
         l_addr  <= '0;
         l_tx    <= 8'h00;
      end else begin
         l_state <= next_l_state;
         l_cnt   <= next_l_cnt;
         l_sr    <= next_l_sr;
         l_addr  <= next_l_addr;
         l_tx    <= next_l_tx;
      end
   end

   // Results outlive the frame: the core reads them after select rises
   always_ff @(posedge sck_in or posedge reset_in) begin
      if (reset_in) begin
         l_page  <= '0;
         l_ptr   <= '0;
         l_mask  <= '0;
         l_lock  <= 8'h00;
         h_cmd   <= EE_CMD_NONE;
         h_ok    <= 1'b0;
         busy_l1 <= 1'b0;
         busy_l2 <= 1'b0;
         arm_l1  <= 1'b0;
         arm_l2  <= 1'b0;
      end else begin
         l_page  <= next_l_page;
         l_ptr   <= next_l_ptr;
         l_mask  <= next_l_mask;
         l_lock  <= next_l_lock;
         h_cmd   <= next_h_cmd;
         h_ok    <= next_h_ok;
         busy_l1 <= busy;
         busy_l2 <= busy_l1;
         arm_l1  <= armed;
         arm_l2  <= arm_l1;
      end
   end

   always_ff @(posedge sck_in) begin
      if (l_state == EE_LK_DATA && byte_end) begin
         l_buf[l_ptr] <= byte_in;
      end
   end

   // ****************************************
   // Serial output, falling edge
   // ****************************************
   always_comb begin
      next_so_oe = (l_state == EE_LK_RDATA) || (l_state == EE_LK_STAT);
      next_so    = l_tx[~l_cnt[2:0]];
   end

   always_ff @(negedge sck_in or posedge l_clr) begin
      if (l_clr) begin
         so_out    <= 1'b0;
         so_oe_out <= 1'b0;
      end else begin
         so_out    <= next_so;
         so_oe_out <= next_so_oe;
      end
   end

   // ****************************************
   // Core: pin synchronisers
   // ****************************************
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         // Reset as selected: only a sampled high arms; the edge this makes meets armed low
         cs_s1 <= 1'b0;
         cs_s2 <= 1'b0;
         cs_s3 <= 1'b0;
         wp_s1 <= 1'b1;
         wp_s2 <= 1'b1;
      end else begin
         cs_s1 <= cs_n_in;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         wp_s1 <= wp_n_in;
         wp_s2 <= wp_s1;
      end
   end

   assign cs_rise = cs_s2 & ~cs_s3;

   // ****************************************
   // Core: write latch, commit and write timer
   // ****************************************
   always_comb begin
      next_armed     = armed | cs_s2;
      next_wel       = wel;
      next_busy      = busy;
      next_timer     = timer;
      next_lock_area = lock_area;
      next_wp_drop   = ~cs_s2 & (wp_drop | ~wp_s2);
      commit_wr      = 1'b0;
      if (busy) begin
         next_timer = timer - 1'b1;
         if (timer == TW'(1)) begin
            next_busy = 1'b0;
            next_wel  = 1'b0;
         end
      end else if (cs_rise && armed) begin
         unique case (h_cmd)
            EE_CMD_SET_LATCH:   next_wel = wel | h_ok;
            EE_CMD_CLEAR_LATCH: next_wel = wel & ~h_ok;
            EE_CMD_WRITE, EE_CMD_LOCK: begin
               if (h_ok && wel && wp_s2 && !wp_drop) begin
                  next_busy  = 1'b1;
                  next_timer = TW'(WRITE_CYCLES);
                  if (h_cmd == EE_CMD_WRITE) begin
                     commit_wr = 1'b1;
                  end else begin
                     next_lock_area = l_lock[`EE_STAT_LOCK_MSB:`EE_STAT_LOCK_LSB];
                  end
               end
            end
            EE_CMD_NONE, EE_CMD_READ: next_wel = wel;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         armed     <= 1'b0;
         wel       <= 1'b0;
         busy      <= 1'b0;
         timer     <= '0;
         lock_area <= `EE_LOCK_RESET;
         wp_drop   <= 1'b0;
      end else begin
         armed     <= next_armed;
         wel       <= next_wel;
         busy      <= next_busy;
         timer     <= next_timer;
         lock_area <= next_lock_area;
         wp_drop   <= next_wp_drop;
      end
   end

   // Buffer is frozen after select rises, so one cycle copies the page
   always_ff @(posedge ref_clk_in) begin
      if (commit_wr) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (l_mask[i]) begin
               mem[{l_page, PW'(i)}] <= l_buf[i];
            end
         end
      end
   end

   // ****************************************
   // Observed outputs
   // ****************************************
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         busy_out             <= 1'b0;
         write_latch_out      <= 1'b0;
         lock_area_select_out <= `EE_LOCK_RESET;
      end else begin
         busy_out             <= next_busy;
         write_latch_out      <= next_wel;
         lock_area_select_out <= next_lock_area;
      end
   end

endmodule
`default_nettype wire

// ==== ee_cmd_assertions.sv ====
// Purpose: port checks of the command logic
// Assumes: bound into ee_cmd, write cycle length handed on
// Notes:   busy span counted in helper logic, not unrolled
`timescale 1ns/1ps
`default_nettype none
module ee_cmd_assertions #(
   parameter int WRITE_CYCLES = 20
) (
   // Core side
   input wire logic       ref_clk_in,
   input wire logic       reset_in,
   input wire logic       wp_n_in,
   input wire logic       busy_out,
   input wire logic       write_latch_out,
   input wire logic [2:0] lock_area_select_out,
   // Serial side
   input wire logic       sck_in,
   input wire logic       cs_n_in,
   input wire logic       si_in,
   input wire logic       so_out,
   input wire logic       so_oe_out
);
   int         busy_cnt;
   int         next_busy_cnt;
   logic [7:0] bits;
   logic [7:0] next_bits;
   // ****************************************
   // Helper counts
   // ****************************************
   always_comb begin
      next_busy_cnt = busy_out ? busy_cnt + 1 : 0;
      next_bits     = (bits == 8'hFF) ? bits : bits + 8'h01;
   end
   always_ff @(posedge ref_clk_in) begin
      busy_cnt <= reset_in ? 0 : next_busy_cnt;
   end
   // Cleared by deselect, as the frame logic is
   always_ff @(posedge sck_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         bits <= 8'h00;
      end else begin
         bits <= next_bits;
      end
   end
   sequence s_deselected;
      cs_n_in ##1 cs_n_in;
   endsequence
   sequence s_commit;
      $rose(busy_out) ##0 cs_n_in;
   endsequence
   property p_commit;
      @(posedge ref_clk_in) disable iff (reset_in) s_commit |-> $past(cs_n_in, 3);
   endproperty
   chk_oe_idle: assert property (
      @(posedge ref_clk_in) disable iff (reset_in) s_deselected |-> !so_oe_out)
      else $error("serial output driven while deselected");
   chk_reset_state: assert property (
      @(posedge ref_clk_in) disable iff (reset_in) $fell(reset_in) |->
         !busy_out && !write_latch_out && lock_area_select_out == 3'h0 && !so_oe_out)
      else $error("state not cleared by reset");
   chk_busy_span: assert property (
      @(posedge ref_clk_in) disable iff (reset_in) $fell(busy_out) |-> busy_cnt == WRITE_CYCLES)
      else $error("write cycle length wrong");
   chk_latch_clear: assert property (
      @(posedge ref_clk_in) disable iff (reset_in) $fell(busy_out) |-> ##[0:1] !write_latch_out)
      else $error("write latch kept after write cycle");
   chk_busy_latch: assert property (
      @(posedge ref_clk_in) disable iff (reset_in) busy_out |-> write_latch_out)
      else $error("write cycle without write latch");
   chk_commit_cs: assert property (p_commit)
      else $error("write started without deselect");
   chk_lock_commit: assert property (
      @(posedge ref_clk_in) disable iff (reset_in)
         $changed(lock_area_select_out) |-> $rose(busy_out))
      else $error("lock code changed outside a write start");
   chk_busy_wp: assert property (
      @(posedge ref_clk_in) disable iff (reset_in)
         $rose(busy_out) |-> $past(wp_n_in, 3) && $past(wp_n_in, 4))
      else $error("write started while protected");
   chk_latch_set: assert property (
      @(posedge ref_clk_in) disable iff (reset_in)
         $rose(write_latch_out) |-> cs_n_in && !$past(busy_out))
      else $error("write latch set while busy or selected");
   chk_oe_start: assert property (
      @(posedge sck_in) disable iff (reset_in || cs_n_in)
         $rose(so_oe_out) |-> bits == 8'h08 || bits == 8'h18)
      else $error("serial output enabled at wrong bit");
endmodule
bind ee_cmd ee_cmd_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) ee_cmd_assertions_i (
   .ref_clk_in(ref_clk_in), .reset_in(reset_in), .wp_n_in(wp_n_in), .busy_out(busy_out),
   .write_latch_out(write_latch_out), .lock_area_select_out(lock_area_select_out),
   .sck_in(sck_in), .cs_n_in(cs_n_in), .si_in(si_in), .so_out(so_out), .so_oe_out(so_oe_out)
);
`default_nettype wire

// ==== ee_host.sv ====
// Purpose: serial master standing in for the host controller
// Assumes: mode 0, clock still between selections
// Notes:   released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module ee_host (
   // Serial pins
   output var  logic sck_out,
   output var  logic cs_n_out,
   output var  logic si_out,
   input  wire logic so_in,
   input  wire logic so_oe_in
);
   initial begin
      sck_out  = 1'b0;
      cs_n_out = 1'b1;
      si_out   = 1'b1;
   end
   // ****************************************
   // One selection of n bits
   // ****************************************
   task automatic xfer(input logic [255:0] tx, input int n, output logic [255:0] rx);
      rx       = '0;
      cs_n_out = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         si_out  = tx[i];
         #15;
         sck_out = 1'b1;
         rx      = {rx[254:0], so_oe_in ? so_in : 1'bx};
         #15;
         sck_out = 1'b0;
      end
      #15;
      cs_n_out = 1'b1;
      si_out   = ~si_out;
      // Room for the core to see the deselect
      #200;
   endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose: self-checking bench of the command logic against a byte model
// Assumes: ee_host drives the serial pins
// Notes:   write cycle shortened to 40 core cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int WC = 40;
   logic         ref_clk_in = 1'b0;
   logic         reset_in   = 1'b1;
   logic         wp_n_in    = 1'b1;
   wire          sck;
   wire          cs_n;
   wire          si;
   wire          so;
   wire          so_oe;
   wire          busy;
   wire          latch;
   wire [2:0]    lock;
   logic [255:0] rx;
   logic [31:0]  seed       = 32'h50959976;
   int           num_errors = 0;
   int           cmp_count  = 0;
   int           mem [int];
   int           lock_m     = 0;

   always #20 ref_clk_in = ~ref_clk_in;

   ee_cmd #(.WRITE_CYCLES(WC)) ee_cmd_i (
      .ref_clk_in(ref_clk_in), .reset_in(reset_in), .sck_in(sck), .cs_n_in(cs_n),
      .si_in(si), .wp_n_in(wp_n_in), .so_out(so), .so_oe_out(so_oe), .busy_out(busy),
      .write_latch_out(latch), .lock_area_select_out(lock));
   ee_host ee_host_i (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_in(so_oe));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 2 * WC && busy !== 1'b0; i++) begin
         @(negedge ref_clk_in);
      end
      check("idle", busy, 1'b0);
   endtask
   task automatic stat(input logic [7:0] exp);
      ee_host_i.xfer(256'h050000, 24, rx);
      check("status", rx[15:8], exp);
      check("status again", rx[7:0], exp);
   endtask
   task automatic wr(input logic [9:0] a, input int n, input bit en, input bit wp, input int ex);
      logic [255:0] tx;
      logic [7:0]   d [$];
      bit           ok;
      ok = en && wp && ex == 0;
      @(posedge ref_clk_in);
      wp_n_in <= wp;
      repeat (4) @(posedge ref_clk_in);
      if (en) begin
         ee_host_i.xfer(256'h06, 8, rx);
      end
      tx = {8'h02, 6'h00, a};
      for (int k = 0; k < n; k++) begin
         d.push_back(xs());
         tx = {tx[247:0], d[k]};
      end
      ee_host_i.xfer(tx << ex, 24 + 8 * n + ex, rx);
      @(negedge ref_clk_in);
      check("busy", busy, ok);
      if (ok) begin
         stat(8'hFF);
         ee_host_i.xfer(256'h04, 8, rx);
         for (int k = 0; k < n; k++) begin
            mem[{a[9:4], a[3:0] + k[3:0]}] = d[k];
         end
      end
      wait_idle();
      check("latch", latch, en && !ok);
      ee_host_i.xfer(256'h04, 8, rx);
      @(posedge ref_clk_in);
      wp_n_in <= 1'b1;
   endtask
   task automatic rd(input logic [9:0] a, input int n);
      ee_host_i.xfer(256'({8'h03, 6'h00, a}) << (8 * n), 24 + 8 * n, rx);
      for (int k = 0; k < n; k++) begin
         check("read", rx[8 * (n - 1 - k) +: 8], 8'(mem[(a + k) % 1024]));
      end
   endtask
   task automatic lk(input logic [2:0] code, input bit en);
      logic [7:0] r;
      r = xs();
      if (en) begin
         ee_host_i.xfer(256'h06, 8, rx);
         lock_m = code;
      end
      ee_host_i.xfer({8'h01, 5'h00, r[2:0], 5'h00, code}, 24, rx);
      @(negedge ref_clk_in);
      check("lock busy", busy, en);
      wait_idle();
      check("lock", lock, 8'(lock_m));
      stat({5'h00, lock_m[2:0]});
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (10) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      check("oe", so_oe, 1'b0);
      check("latch", latch, 1'b0);
      stat(8'h00);
      ee_host_i.xfer(256'h06, 8, rx);
      @(negedge ref_clk_in);
      check("set latch", latch, 1'b1);
      ee_host_i.xfer(256'h04, 8, rx);
      @(negedge ref_clk_in);
      check("clear latch", latch, 1'b0);
      ee_host_i.xfer(256'h06020005AB, 40, rx);
      @(negedge ref_clk_in);
      check("voided latch", latch, 1'b0);
      check("voided write", busy, 1'b0);
      wr(10'h3F8, 18, 1'b1, 1'b1, 0);
      wr(10'h000, 1, 1'b1, 1'b1, 0);
      wr(10'h005, 2, 1'b0, 1'b1, 0);
      wr(10'h005, 2, 1'b1, 1'b0, 0);
      wr(10'h005, 2, 1'b1, 1'b1, 3);
      rd(10'h3FE, 3);
      rd(10'h3F0, 16);
      for (int c = 0; c < 8; c++) begin
         lk(c[2:0], 1'b1);
      end
      lk(3'h5, 1'b0);
      conclude();
   end
   initial begin
      repeat (40000) @(posedge ref_clk_in);
      num_errors++;
      conclude();
   end
endmodule
`default_nettype wire
